// >>> verif/test_watchdog_timer_with_key_reset.sv
// Self-checking bench for the watchdog block
`timescale 1ns/10ps
module test_watchdog_timer_with_key_reset
	import wdt_pkg::*;
;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, lastErr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic auxClkIn, rcClkIn, extResetPin_n, portAFall, sysIrq, irq;
	logic fullReset, normalReset, pcSpReset, wakeUp, expiryStatusFlag, powerDownFlag;
	logic [3:0] divider = 4'h0;
	int fail_count, total_checks, cycles, nrCnt, pcCnt, frCnt, wkCnt, waited, old;

	watchdog_timer_with_key_reset watchdog_timer_with_key_reset_i (.clk(clk), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .auxClkIn(auxClkIn),
		.rcClkIn(rcClkIn), .extResetPin_n(extResetPin_n), .portAFall(portAFall),
		.sysIrq(sysIrq), .fullReset(fullReset), .normalReset(normalReset),
		.pcSpReset(pcSpReset), .wakeUp(wakeUp), .expiryStatusFlag(expiryStatusFlag),
		.powerDownFlag(powerDownFlag), .irq(irq));

	// ==========
	// Clocks, event counters, timeout
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Slow clocks derived from clk keep the overflow at 1024 cycles for select 000
	always @(posedge clk) begin
		divider <= divider + 4'h1;
		auxClkIn <= divider[1];
		rcClkIn <= divider[2];
		cycles++;
		if (normalReset === 1'b1) nrCnt++;
		if (pcSpReset === 1'b1) pcCnt++;
		if (fullReset === 1'b1) frCnt++;
		if (wakeUp === 1'b1) wkCnt++;
		if (cycles > 12000) begin
			fail_count++;
			report_and_stop;
		end
	end

	// ==========
	// Tasks
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		// No limit of its own: pready or the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		lastErr = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic waitEvt(ref int cnt, input int lim);
		int start;
		start = cnt;
		waited = 0;
		while (cnt == start && waited < lim) begin
			// Falling edge: counters and outputs have settled
			@(negedge clk);
			waited++;
		end
	endtask
	task automatic check(input string name, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========
	// Scenarios
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rst_n, portAFall, sysIrq, extResetPin_n} = 4'b0001;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, ADDR_CTRL, 0, rd);
		check("ctrl", rd, {24'h0, CTRL_RESET});
		apb(0, ADDR_FLAGS, 0, rd);
		check("flags", rd & 32'h70, 0);
		apb(0, 12'h020, 0, rd);
		check("unmapped", {31'h0, lastErr}, 1);
		apb(1, ADDR_INTMASK, 32'hF, rd);
		apb(1, ADDR_CTRL, {24'h0, KEY_ENABLE, 3'h0}, rd);
		waitEvt(nrCnt, 1500);
		check("period", {31'h0, waited > 1010 && waited < 1050}, 1);
		check("expiry", expiryStatusFlag, 1);
		check("irq", irq, 1);
		apb(0, ADDR_INTSTAT, 0, rd);
		check("stat", rd & 32'h1, 1);
		apb(0, ADDR_INTSTAT, 0, rd);
		check("statclr", rd, 0);
		check("irqclr", irq, 0);
		old = nrCnt;
		repeat (8) begin
			repeat (200) @(posedge clk);
			apb(1, ADDR_CMD, 32'h1, rd);
		end
		check("cleared", nrCnt, old);
		apb(1, ADDR_CTRL, {24'h0, KEY_DISABLE, 3'h0}, rd);
		repeat (1500) @(posedge clk);
		check("disabled", nrCnt, old);
		apb(1, ADDR_CTRL, {24'h0, KEY_ENABLE, 3'h0}, rd);
		apb(1, ADDR_CMD, 32'h2, rd);
		repeat (3) @(posedge clk);
		check("pdf", powerDownFlag, 1);
		check("expoff", expiryStatusFlag, 0);
		old = wkCnt;
		waitEvt(pcCnt, 1500);
		repeat (3) @(posedge clk);
		check("pcsp", pcCnt, 1);
		check("expon", expiryStatusFlag, 1);
		check("wdtwake", {31'h0, wkCnt > old}, 1);
		for (int s = 0; s < 2; s++) begin
			apb(1, ADDR_CMD, 32'h2, rd);
			old = wkCnt;
			if (s == 0) sysIrq <= 1'b1;
			else portAFall <= 1'b1;
			repeat (8) @(posedge clk);
			{sysIrq, portAFall} <= 2'b00;
			check("wake", wkCnt, old + 1);
		end
		apb(1, ADDR_CMD, 32'h2, rd);
		apb(0, ADDR_EVENT, 0, rd);
		check("halted", rd, 32'h3);
		apb(1, ADDR_CMD, 32'h4, rd);
		apb(0, ADDR_EVENT, 0, rd);
		check("running", rd, 32'h1);
		check("pdfrun", powerDownFlag, 0);
		old = frCnt;
		apb(1, ADDR_CTRL, 32'h0, rd);
		waitEvt(frCnt, 100);
		check("keyrst", frCnt, old + 1);
		check("keydelay", {31'h0, waited >= 16 && waited <= 28}, 1);
		apb(0, ADDR_FLAGS, 0, rd);
		check("keyflag", rd & 32'h1, 1);
		apb(0, ADDR_INTSTAT, 0, rd);
		check("allevents", rd, 32'hF);
		apb(1, ADDR_CTRL, {24'h0, KEY_ENABLE, 3'h3}, rd);
		apb(0, ADDR_FLAGS, 0, rd);
		check("keyhold", rd & 32'h1, 1);
		apb(1, ADDR_FLAGS, 0, rd);
		apb(0, ADDR_FLAGS, 0, rd);
		check("keyzero", rd & 32'h1, 0);
		extResetPin_n <= 1'b0;
		repeat (10) @(posedge clk);
		check("pinlow", normalReset, 1);
		extResetPin_n <= 1'b1;
		repeat (10) @(posedge clk);
		check("pinhigh", normalReset, 0);
		report_and_stop;
	end
endmodule

// >>> verif/wdt_checker.sv
// Port-level assertions for the watchdog block
`timescale 1ns/10ps
module wdt_checker
	import wdt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic extResetPin_n,
	input wire logic sysIrq,
	input wire logic fullReset,
	input wire logic normalReset,
	input wire logic pcSpReset,
	input wire logic wakeUp,
	input wire logic expiryStatusFlag,
	input wire logic powerDownFlag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// Bus answer
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	ready_wait_a: assert property ($rose(penable) && psel |=> pready) else $error("ready late");
	err_read_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
		else $error("bad error answer");
	flag_gap_a: assert property (pready && !pwrite && paddr == ADDR_FLAGS |->
		prdata[6:4] == 3'h0) else $error("flag gap not zero");
	// ==========
	// Resets and wake
	key_pulse_a: assert property (fullReset |=> !fullReset) else $error("key reset long");
	pin_reset_a: assert property (!extResetPin_n [*6] |-> normalReset)
		else $error("pin reset missing");
	run_expiry_a: assert property ($rose(normalReset) && extResetPin_n |->
		##[0:2] expiryStatusFlag) else $error("no expiry flag");
	halt_expiry_a: assert property (pcSpReset |-> !normalReset ##[0:2] expiryStatusFlag)
		else $error("halted overflow wrong");
	irq_wake_a: assert property ($rose(sysIrq) && powerDownFlag |-> ##[1:5] wakeUp)
		else $error("no wake");
	halt_flags_a: assert property (pready && pwrite && paddr == ADDR_CMD &&
		pwdata[CMD_HALT_BIT] |-> ##[1:2] powerDownFlag && !expiryStatusFlag)
		else $error("halt flags wrong");
endmodule
bind watchdog_timer_with_key_reset wdt_checker wdt_checker_i (.clk(clk), .rst_n(rst_n),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .extResetPin_n(extResetPin_n),
	.sysIrq(sysIrq), .fullReset(fullReset), .normalReset(normalReset),
	.pcSpReset(pcSpReset), .wakeUp(wakeUp), .expiryStatusFlag(expiryStatusFlag),
	.powerDownFlag(powerDownFlag));

// >>> verilog/watchdog_timer_with_key_reset.sv
// Watchdog with key-guarded enable, timeout select, wake-up and reset outputs
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
module watchdog_timer_with_key_reset
	import wdt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic auxClkIn,
	input wire logic rcClkIn,
	input wire logic extResetPin_n,
	input wire logic portAFall,
	input wire logic sysIrq,
	output logic fullReset,
	output logic normalReset,
	output logic pcSpReset,
	output logic wakeUp,
	output logic expiryStatusFlag,
	output logic powerDownFlag,
	output logic irq
);

	typedef enum logic [1:0] {
		RUN_STATE = 2'b00,
		HALT_STATE = 2'b01,
		KEYWAIT_STATE = 2'b10
	} pm_type;

	// ==========================================================
	// Helpers
	function automatic logic syncEdge(input logic [2:0] s);
		syncEdge = s[1] & ~s[2];
	endfunction

	function automatic logic keyValid(input logic [4:0] k);
		keyValid = (k == KEY_ENABLE) || (k == KEY_DISABLE);
	endfunction

	function automatic logic [4:0] periodExp(input logic [2:0] sel);
		case (sel)
			3'h0: periodExp = 5'h08;
			3'h1: periodExp = 5'h0A;
			3'h2: periodExp = 5'h0C;
			3'h3: periodExp = 5'h0E;
			default: periodExp = 5'(5'h0B + {2'h0, sel});
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers (three stages, second and third compared)
	logic [2:0] auxSync_ff;
	logic [2:0] rcSync_ff;
	logic [2:0] rstPinSync_ff;
	logic [2:0] portSync_ff;
	logic [2:0] irqSync_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			auxSync_ff <= 3'h0;
			rcSync_ff <= 3'h0;
			rstPinSync_ff <= 3'h7;
			portSync_ff <= 3'h0;
			irqSync_ff <= 3'h0;
		end else begin
			auxSync_ff <= {auxSync_ff[1:0], auxClkIn};
			rcSync_ff <= {rcSync_ff[1:0], rcClkIn};
			rstPinSync_ff <= {rstPinSync_ff[1:0], extResetPin_n};
			portSync_ff <= {portSync_ff[1:0], portAFall};
			irqSync_ff <= {irqSync_ff[1:0], sysIrq};
		end
	end

	// auxiliary clock becomes a tick enable
	// counter advances on auxiliary ticks only
	logic auxTick;
	logic rcTick;
	logic rstPinLow;
	logic portEvent;
	logic irqLevel;
	assign auxTick = syncEdge(auxSync_ff);
	assign rcTick = syncEdge(rcSync_ff);
	assign rstPinLow = ~rstPinSync_ff[1] & ~rstPinSync_ff[2];
	assign portEvent = syncEdge(portSync_ff);
	assign irqLevel = irqSync_ff[1] & irqSync_ff[2];

	// ==========================================================
	// APB decode
	logic wrEn;
	logic rdEn;
	logic mapped;
	assign wrEn = psel & penable & pwrite & pready;
	assign rdEn = psel & penable & ~pwrite & pready;
	assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_FLAGS) || (paddr == ADDR_EVENT)
		|| (paddr == ADDR_CMD) || (paddr == ADDR_INTSTAT) || (paddr == ADDR_INTMASK);

	// ==========================================================
	// Control register
	logic [7:0] ctrl_ff;
	logic [4:0] key;
	logic [2:0] tsel;
	logic wdtOn;
	logic ctrlWr;
	assign key = ctrl_ff[7:KEY_LSB];
	assign tsel = ctrl_ff[2:0];
	assign wdtOn = (key == KEY_ENABLE);
	assign ctrlWr = wrEn && paddr == ADDR_CTRL;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RESET;
		end else if (ctrlWr) begin
			ctrl_ff <= pwdata[7:0];
		end
	end

	// ==========================================================
	// Mode flags and command strobes
	logic keyRstFlag_ff;
	logic coreKeep_ff;
	logic cmdClear;
	logic cmdHalt;
	logic cmdRun;
	logic keyFire;
	assign cmdClear = wrEn && paddr == ADDR_CMD && pwdata[CMD_CLEAR_BIT];
	assign cmdHalt = wrEn && paddr == ADDR_CMD && pwdata[CMD_HALT_BIT];
	assign cmdRun = wrEn && paddr == ADDR_CMD && pwdata[CMD_RUN_BIT];

	// set on key reset; only software clears, set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keyRstFlag_ff <= 1'b0;
			coreKeep_ff <= 1'b0;
		end else begin
			if (keyFire) begin
				keyRstFlag_ff <= 1'b1;
			end else if (wrEn && paddr == ADDR_FLAGS) begin
				keyRstFlag_ff <= pwdata[KEY_RST_FLAG_BIT];
			end
			if (wrEn && paddr == ADDR_FLAGS) begin
				coreKeep_ff <= pwdata[CORE_KEEP_BIT];
			end
		end
	end

	// ==========================================================
	// Invalid key delay, counted in internal RC ticks
	logic [1:0] keyDly_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keyDly_ff <= 2'h0;
		end else if (keyValid(key)) begin
			keyDly_ff <= 2'h0;
		end else if (rcTick && keyDly_ff != 2'(KEY_DELAY_CYCLES + 1)) begin
			keyDly_ff <= keyDly_ff + 2'h1;
		end
	end
	// Fires on the third RC tick; the partial first period gives two to three cycles
	assign keyFire = !keyValid(key) && rcTick && keyDly_ff == 2'(KEY_DELAY_CYCLES);

	// ==========================================================
	// Power mode
	pm_type pm_ff;
	logic overflow;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pm_ff <= RUN_STATE;
		end else begin
			case (pm_ff)
				RUN_STATE: begin
					if (cmdHalt) begin
						pm_ff <= HALT_STATE;
					end
				end
				HALT_STATE: begin
					if (rstPinLow || portEvent || irqLevel || overflow || cmdRun) begin
						pm_ff <= RUN_STATE;
					end
				end
				default: pm_ff <= RUN_STATE;
			endcase
		end
	end

	// ==========================================================
	// Counter
	logic [COUNT_W-1:0] cnt_ff;
	logic [2:0] prevSel_ff;
	logic prevOn_ff;
	logic restart;
	logic [4:0] pexp;
	assign pexp = periodExp(tsel);
	assign overflow = wdtOn && auxTick && (cnt_ff == COUNT_W'((1 << pexp) - 1));
	assign restart = (tsel != prevSel_ff) || (wdtOn && !prevOn_ff);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prevSel_ff <= CTRL_RESET[2:0];
			prevOn_ff <= 1'b1;
		end else begin
			prevSel_ff <= tsel;
			prevOn_ff <= wdtOn;
		end
	end

	// clear sources; halt clears, disabled key stops counting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (rstPinLow || !keyValid(key) || cmdClear || cmdHalt || restart
				|| overflow || !wdtOn) begin
			cnt_ff <= '0;
		end else if (auxTick) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// ==========================================================
	// Status flags and reset outputs
	// overflow sets expiry; halt sets power-down, clears expiry
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expiryStatusFlag <= 1'b0;
			powerDownFlag <= 1'b0;
		end else begin
			if (overflow) begin
				expiryStatusFlag <= 1'b1;
			end else if (cmdHalt) begin
				expiryStatusFlag <= 1'b0;
			end
			if (cmdHalt) begin
				powerDownFlag <= 1'b1;
			end else if (cmdRun) begin
				powerDownFlag <= 1'b0;
			end
		end
	end

	// full reset restarts program at zero
	// reset pin held low gives normal reset until released
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fullReset <= 1'b0;
			normalReset <= 1'b0;
			pcSpReset <= 1'b0;
			wakeUp <= 1'b0;
		end else begin
			fullReset <= keyFire;
			normalReset <= rstPinLow || (overflow && pm_ff == RUN_STATE);
			// overflow in sleep resets only PC and SP
			pcSpReset <= overflow && pm_ff == HALT_STATE;
			wakeUp <= pm_ff == HALT_STATE
				&& (rstPinLow || portEvent || irqLevel || overflow);
		end
	end

	// ==========================================================
	// Interrupt status: read clears, set wins
	logic [3:0] intStat_ff;
	logic [3:0] intMask_ff;
	logic [3:0] events;
	assign events = {keyFire, pm_ff == HALT_STATE && wakeUp == 1'b0
		&& (rstPinLow || portEvent || irqLevel || overflow), cmdHalt, overflow};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intStat_ff <= 4'h0;
			intMask_ff <= 4'h0;
			irq <= 1'b0;
		end else begin
			if (rdEn && paddr == ADDR_INTSTAT) begin
				intStat_ff <= events;
			end else begin
				intStat_ff <= intStat_ff | events;
			end
			if (wrEn && paddr == ADDR_INTMASK) begin
				intMask_ff <= pwdata[3:0];
			end
			irq <= |(intStat_ff & intMask_ff);
		end
	end

	// ==========================================================
	// APB answer: one wait state, registered read data
	logic [7:0] flagsRd;
	assign flagsRd = {coreKeep_ff, 3'h0, 3'h0, keyRstFlag_ff};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite) begin
				case (paddr)
					ADDR_CTRL: prdata <= {24'h0, ctrl_ff};
					ADDR_FLAGS: prdata <= {24'h0, flagsRd};
					ADDR_EVENT: prdata <= {28'h0, 2'h0, pm_ff == HALT_STATE, wdtOn};
					ADDR_INTSTAT: prdata <= {28'h0, intStat_ff};
					ADDR_INTMASK: prdata <= {28'h0, intMask_ff};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

endmodule

// >>> verilog/wdt_pkg.sv
// Constants shared by the watchdog block
package wdt_pkg;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_FLAGS = 12'h004;
	localparam logic [11:0] ADDR_EVENT = 12'h008;
	localparam logic [11:0] ADDR_CMD = 12'h00C;
	localparam logic [11:0] ADDR_INTSTAT = 12'h010;
	localparam logic [11:0] ADDR_INTMASK = 12'h014;
	localparam logic [7:0] CTRL_RESET = 8'h53;
	localparam logic [4:0] KEY_DISABLE = 5'h15;
	localparam logic [4:0] KEY_ENABLE = 5'h0A;
	localparam int KEY_LSB = 3;
	localparam int KEY_RST_FLAG_BIT = 0;
	localparam int CORE_KEEP_BIT = 7;
	localparam int CMD_CLEAR_BIT = 0;
	localparam int CMD_HALT_BIT = 1;
	localparam int CMD_RUN_BIT = 2;
	localparam int EV_EXPIRY = 0;
	localparam int EV_POWERDOWN = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_KEYRST = 3;
	localparam int KEY_DELAY_CYCLES = 2;
	localparam int COUNT_W = 18;
endpackage
